// file: deskew_pkg.sv
package deskew_pkg;

   // ----------------------------------------
   // lane and frame layout
   // ----------------------------------------
   localparam int LANES         = 4;
   localparam int FRAME_LEN     = 10;
   localparam int HALF_LEN      = 5;
   localparam int ODD_PAR_POS   = 4;
   localparam int EVEN_PAR_POS  = 9;
   // deskew reach: relaxed budget 16.50 UI rounded up, covers the tight 6.70 UI case too;
   // taps 0..34 let a lane sit up to 17 UI either side of the reference
   localparam int MAX_SKEW_UI   = 17;
   localparam int DLY_DEPTH     = 2 * MAX_SKEW_UI + 1;
   localparam int DLY_W         = 6;
   localparam int LOCK_FRAMES   = 4;
   localparam int UNLOCK_FRAMES = 4;
   localparam int CNT_W         = 3;
   localparam int FRM_LOCK_HITS = 4;

   typedef struct packed {
      logic [LANES-1:0] data;
      logic             ref_bit;
   } lane_word_t;

   typedef enum logic [1:0] {
      ST_HUNT  = 2'b00,
      ST_CHECK = 2'b01,
      ST_SYNC  = 2'b11
   } frame_state_t;

endpackage : deskew_pkg

// file: lane_deskew_receiver.sv
`timescale 1ns/10ps

module lane_deskew_receiver
(
   input  wire logic                     clk,
   input  wire logic                     reset_n,
   input  wire logic [3:0]               rx_lane_data,
   input  wire logic                     rx_reference_lane,
   input  wire logic                     invert_enable,
   input  wire logic                     out_ready,
   output logic [3:0]                    out_data,
   output logic                          out_valid,
   output logic                          rx_misalign_alarm,
   output logic [3:0]                    lane_locked,
   output logic                          frame_error,
   output logic                          frame_tick
);
   import deskew_pkg::*;

   // ----------------------------------------
   // input synchronisers
   // ----------------------------------------
   lane_word_t sync1_reg;
   lane_word_t sync2_reg;

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         sync1_reg <= '0;
         sync2_reg <= '0;
      end
      else
      begin
         sync1_reg <= {rx_lane_data, rx_reference_lane};
         sync2_reg <= sync1_reg;
      end
   end

   // ----------------------------------------
   // reference history and frame search
   // ----------------------------------------
   // history holds the last ten reference bits, bit 0 newest
   logic [FRAME_LEN-1:0] ref_hist_reg;
   logic [MAX_SKEW_UI-1:0] ref_dly_reg; // reference runs MAX_SKEW_UI behind lane tap 0
   logic [3:0]           phase_reg;
   logic [3:0]           phase_next;
   logic [CNT_W-1:0]     frm_cnt_reg;
   frame_state_t         fstate_reg;
   logic                 par_ok;
   logic                 frame_end;

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         {ref_hist_reg, ref_dly_reg} <= '0;
      else
         {ref_hist_reg, ref_dly_reg} <= {ref_hist_reg[FRAME_LEN-2:0], ref_dly_reg, sync2_reg.ref_bit};
   end

   // newest bit is even parity, bit 5 is odd parity
   always_comb
   begin
      par_ok = (^ref_hist_reg[HALF_LEN-1:0]) == 1'b0 && (^ref_hist_reg[FRAME_LEN-1:HALF_LEN]) == 1'b1;
   end

   assign phase_next = (phase_reg == 4'(FRAME_LEN - 1)) ? 4'h0 : phase_reg + 4'h1;
   assign frame_end  = (phase_reg == 4'(EVEN_PAR_POS));

   // frame phase: 0..3 lane samples, 4 odd parity, 5..8 samples, 9 even parity
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         fstate_reg  <= ST_HUNT;
         phase_reg   <= 4'h0;
         frm_cnt_reg <= '0;
      end
      else
      begin
         phase_reg <= phase_next;
         case (fstate_reg)
            ST_HUNT:
            begin
               // alternating parity marks a candidate boundary, so slip to it
               if (par_ok)
               begin
                  phase_reg   <= 4'h0;
                  frm_cnt_reg <= '0;
                  fstate_reg  <= ST_CHECK;
               end
            end
            ST_CHECK:
            begin
               if (frame_end)
               begin
                  if (!par_ok)
                     fstate_reg <= ST_HUNT;
                  else if (frm_cnt_reg == CNT_W'(FRM_LOCK_HITS - 1))
                  begin
                     fstate_reg  <= ST_SYNC;
                     frm_cnt_reg <= '0;
                  end
                  else
                     frm_cnt_reg <= frm_cnt_reg + 1'b1;
               end
            end
            ST_SYNC:
            begin
               if (frame_end)
               begin
                  if (par_ok)
                     frm_cnt_reg <= '0;
                  else if (frm_cnt_reg == CNT_W'(FRM_LOCK_HITS - 1))
                     fstate_reg <= ST_HUNT;
                  else
                     frm_cnt_reg <= frm_cnt_reg + 1'b1;
               end
            end
            default:
               fstate_reg <= ST_HUNT;
         endcase
      end
   end

   // ----------------------------------------
   // per-lane delay lines and skew search
   // ----------------------------------------
   // reference copies lane n at its sample slot; the reference itself is delayed by
   // MAX_SKEW_UI so late lanes can still be matched, and each lane adds its own delay
   logic [DLY_DEPTH-1:0] lane_hist_reg [LANES];
   logic [DLY_W-1:0]     lane_dly_reg  [LANES];
   logic [CNT_W-1:0]     good_cnt_reg  [LANES];
   logic [CNT_W-1:0]     bad_cnt_reg   [LANES];
   logic [LANES-1:0]     lane_bit;
   logic [LANES-1:0]     lane_miss_reg;
   logic [LANES-1:0]     lane_miss_frame;
   logic [LANES-1:0]     hit_now;
   logic [LANES-1:0]     lock_reg;
   logic                 in_sync;
   logic                 odd_half;

   assign in_sync  = (fstate_reg == ST_SYNC);
   assign odd_half = (phase_reg < 4'(HALF_LEN));

   generate
      for (genvar g = 0; g < LANES; g++)
      begin : gen_lane
         // sample slot of lane g within each half of the frame
         localparam logic [3:0] SLOT = 4'(LANES - 1 - g);
         logic slot_hit;
         logic cmp_bit;

         assign slot_hit   = in_sync && (phase_reg == SLOT || phase_reg == SLOT + 4'(HALF_LEN));
         // newer delay taps mean less compensation; tap MAX_SKEW_UI aligns a lane with no skew
         assign lane_bit[g] = lane_hist_reg[g][lane_dly_reg[g]];
         assign cmp_bit     = ref_hist_reg[0];
         assign hit_now[g]  = slot_hit && (lane_bit[g] == cmp_bit);

         always_ff @(posedge clk or negedge reset_n)
         begin
            if (!reset_n)
               lane_hist_reg[g] <= '0;
            else
               lane_hist_reg[g] <= {lane_hist_reg[g][DLY_DEPTH-2:0], sync2_reg.data[g]};
         end

         always_ff @(posedge clk or negedge reset_n)
         begin
            if (!reset_n)
            begin
               lane_dly_reg[g]  <= '0;
               good_cnt_reg[g]  <= '0;
               bad_cnt_reg[g]   <= '0;
               lock_reg[g]      <= 1'b0;
               lane_miss_reg[g] <= 1'b0;
            end
            else
            begin
               if (slot_hit && !hit_now[g])
                  lane_miss_reg[g] <= 1'b1;
               if (frame_end)
               begin
                  lane_miss_reg[g] <= 1'b0;
                  if (!lane_miss_frame[g])
                  begin
                     bad_cnt_reg[g] <= '0;
                     if (good_cnt_reg[g] == CNT_W'(LOCK_FRAMES - 1))
                        lock_reg[g] <= 1'b1;
                     else
                        good_cnt_reg[g] <= good_cnt_reg[g] + 1'b1;
                  end
                  else
                  begin
                     good_cnt_reg[g] <= '0;
                     if (!lock_reg[g] || bad_cnt_reg[g] == CNT_W'(UNLOCK_FRAMES - 1))
                     begin
                        // tracking runs only in ST_SYNC: there an unlocked lane steps its delay after each frame with a miss
                        lock_reg[g]    <= 1'b0;
                        bad_cnt_reg[g] <= '0;
                        lane_dly_reg[g] <= (lane_dly_reg[g] == DLY_W'(2 * MAX_SKEW_UI))
                                           ? '0 : lane_dly_reg[g] + 1'b1;
                     end
                     else
                        bad_cnt_reg[g] <= bad_cnt_reg[g] + 1'b1;
                  end
               end
               if (!in_sync)
               begin
                  lock_reg[g]     <= 1'b0;
                  good_cnt_reg[g] <= '0;
               end
            end
         end
      end
   endgenerate

   assign lane_miss_frame = lane_miss_reg; // frame end is a parity slot, so the register covers all slots

   // ----------------------------------------
   // alarm and error report
   // ----------------------------------------
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         rx_misalign_alarm <= 1'b1;
         lane_locked       <= '0;
         frame_error       <= 1'b0;
         frame_tick        <= 1'b0;
      end
      else
      begin
         rx_misalign_alarm <= !(&lock_reg);
         lane_locked       <= lock_reg;
         frame_tick        <= frame_end && in_sync;
         frame_error       <= frame_end && in_sync && (|lane_miss_frame || !par_ok);
      end
   end

   // ----------------------------------------
   // output word and two-entry buffer
   // ----------------------------------------
   // the output word is taken at every phase, parity slots included; one nibble per UI
   logic [3:0]       word_in;
   logic             push;
   logic [3:0]       buf_reg [2];
   logic [1:0]       count_reg;
   logic             rd_ptr_reg;
   logic             wr_ptr_reg;

   // a word stalled by the receiver stays in the buffer; overflow drops the newest word
   assign word_in = lane_bit ^ ((invert_enable && odd_half) ? 4'hF : 4'h0);
   assign push    = (&lock_reg) && (count_reg != 2'h2 || out_ready);
   assign out_valid = (count_reg != 2'h0);
   assign out_data  = buf_reg[rd_ptr_reg];

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         buf_reg[0] <= 4'h0;
         buf_reg[1] <= 4'h0;
         count_reg  <= 2'h0;
         rd_ptr_reg <= 1'b0;
         wr_ptr_reg <= 1'b0;
      end
      else
      begin
         if (push)
         begin
            buf_reg[wr_ptr_reg] <= word_in;
            wr_ptr_reg          <= ~wr_ptr_reg;
         end
         if (out_valid && out_ready)
            rd_ptr_reg <= ~rd_ptr_reg;
         count_reg <= count_reg + 2'(push) - 2'(out_valid && out_ready);
      end
   end

endmodule : lane_deskew_receiver

// file: lane_deskew_receiver_bench.sv
`timescale 1ns/10ps
module lane_deskew_receiver_bench;
   import deskew_pkg::*;
   logic clk = 0, reset_n = 0, invert_enable = 0, out_ready = 0, inv_src = 0;
   logic [3:0] stuck_mask = 4'h0, rx_lane_data, out_data, lane_locked;
   logic rx_reference_lane, out_valid, rx_misalign_alarm, frame_error, frame_tick;
   int err_total = 0, num_checks = 0, errs_seen = 0, ticks_seen = 0;
   always #20 clk = ~clk;
   // pulses are counted mid-cycle, clear of the edge that launches them
   always @(negedge clk) if (frame_error === 1'b1) errs_seen++;
   always @(negedge clk) if (frame_tick === 1'b1) ticks_seen++;
   source_lane_model u_source_lane_model (.clk(clk), .reset_n(reset_n), .invert_on(inv_src),
      .stuck_mask(stuck_mask), .rx_lane_data(rx_lane_data), .rx_reference_lane(rx_reference_lane));
   lane_deskew_receiver u_lane_deskew_receiver (.clk(clk), .reset_n(reset_n), .rx_lane_data(rx_lane_data),
      .rx_reference_lane(rx_reference_lane), .invert_enable(invert_enable), .out_ready(out_ready),
      .out_data(out_data), .out_valid(out_valid), .rx_misalign_alarm(rx_misalign_alarm),
      .lane_locked(lane_locked), .frame_error(frame_error), .frame_tick(frame_tick));
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   task automatic check(string what, logic [3:0] seen, logic [3:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         err_total++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   function automatic logic [3:0] nib_ok(logic [3:0] n);
      return {3'h0, n[3] == n[2] && n[0] == (n[3] ^ n[1])};
   endfunction : nib_ok
   task automatic wait_alarm(logic lvl, int lim);
      int n;
      n = 0;
      while (rx_misalign_alarm !== lvl && n < lim)
      begin
         @(posedge clk) #1;
         n++;
      end
      check("alarm", {3'h0, rx_misalign_alarm}, {3'h0, lvl});
   endtask : wait_alarm
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : tally_and_finish
   // ----------------------------------------
   // tests
   // ----------------------------------------
   initial
   begin
      #(40 * 40000);
      err_total++;
      tally_and_finish;
   end
   initial
   begin
      void'($urandom(7));
      repeat (5) @(posedge clk);
      #1 check("reset state", {rx_misalign_alarm, 2'h0, out_valid}, 4'h8);
      check("reset locks", lane_locked, 4'h0);
      reset_n = 1;
      // second pass runs with the odd half inverted at both ends
      for (int pass = 0; pass < 2; pass++)
      begin
         invert_enable = 1'(pass);
         inv_src = 1'(pass);
         // words already in flight were coded the old way; let them drain first
         repeat (60) @(posedge clk) #1 out_ready = 1;
         wait_alarm(1'b0, 8000);
         check("all locked", lane_locked, 4'hF);
         errs_seen = 0;
         ticks_seen = 0;
         repeat (600)
         begin
            @(posedge clk) #1 out_ready = 1'($urandom);
            if (out_valid === 1'b1) check("aligned nibble", nib_ok(out_data), 4'h1);
         end
         check("clean frames", {3'h0, errs_seen != 0}, 4'h0);
         check("frame ticks", {3'h0, ticks_seen == 60}, 4'h1);
      end
      repeat (12) @(posedge clk) #1 out_ready = 0;
      check("stalled valid", {3'h0, out_valid}, 4'h1);
      @(posedge clk) #1 out_ready = 1;
      stuck_mask = 4'h4;
      wait_alarm(1'b1, 2000);
      check("errors flagged", {3'h0, errs_seen > 0}, 4'h1);
      repeat (4) @(posedge clk);
      #1 check("drained", {3'h0, out_valid}, 4'h0);
      stuck_mask = 4'h0;
      wait_alarm(1'b0, 8000);
      check("relocked", lane_locked, 4'hF);
      tally_and_finish;
   end
endmodule : lane_deskew_receiver_bench

// file: lane_deskew_receiver_monitor.sv
`timescale 1ns/10ps
module lane_deskew_receiver_monitor
(
   input wire logic       clk,
   input wire logic       reset_n,
   input wire logic [3:0] rx_lane_data,
   input wire logic       rx_reference_lane,
   input wire logic       invert_enable,
   input wire logic       out_ready,
   input wire logic [3:0] out_data,
   input wire logic       out_valid,
   input wire logic       rx_misalign_alarm,
   input wire logic [3:0] lane_locked,
   input wire logic       frame_error,
   input wire logic       frame_tick
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);
   a_alarm_while_unlocked: assert property (!(&lane_locked) ##1 !(&lane_locked) |-> rx_misalign_alarm)
      else $error("alarm low with a lane unlocked");
   a_clear_when_locked: assert property ($fell(rx_misalign_alarm) |-> &lane_locked)
      else $error("alarm cleared before all lanes locked");
   a_lock_loss_alarm: assert property (&$past(lane_locked) && !(&lane_locked) |-> ##[0:1] rx_misalign_alarm)
      else $error("lane lost lock without alarm");
   a_no_push_alarm: assert property ((rx_misalign_alarm && !out_valid) ##1 rx_misalign_alarm[*2] |-> !out_valid)
      else $error("word pushed while misaligned");
   a_hold_on_stall: assert property (out_valid && !out_ready |=> out_valid && $stable(out_data))
      else $error("buffered word lost during stall");
   a_tick_spacing: assert property (frame_tick |=> !frame_tick[*8])
      else $error("frame ticks too close");
   a_tick_period: assert property (frame_tick && !rx_misalign_alarm |-> ##10 frame_tick)
      else $error("frame tick not every ten bits");
   a_error_at_frame: assert property (frame_error |-> frame_tick)
      else $error("frame error off the frame end");
   a_reset_state: assert property ($rose(reset_n) |-> rx_misalign_alarm && !out_valid && lane_locked == 4'h0)
      else $error("wrong state after reset");
   c_lock: cover property ($fell(rx_misalign_alarm));
   c_relapse: cover property ($rose(rx_misalign_alarm));
   c_error: cover property (frame_error);
   c_stall: cover property (out_valid && !out_ready);
endmodule : lane_deskew_receiver_monitor

bind lane_deskew_receiver lane_deskew_receiver_monitor u_lane_deskew_receiver_monitor (.*);

// file: source_lane_model.sv
`timescale 1ns/10ps
module source_lane_model
(
   input  wire logic       clk,
   input  wire logic       reset_n,
   input  wire logic       invert_on,
   input  wire logic [3:0] stuck_mask,
   output logic [3:0]      rx_lane_data,
   output logic            rx_reference_lane
);
   // lanes lead the reference by 16, 11, 5, 0 UI: the relaxed 16.50 UI budget
   localparam int LANE_DLY [4] = '{0, 5, 11, 16};
   localparam int REF_DLY = 16;
   logic [3:0]  slot_reg;
   logic        par_reg;
   logic [1:0]  bit_reg;
   logic [3:0]  nib;
   logic        ref_bit;
   logic [31:0] line_reg [5];
   // lane 2 copies lane 3 and lane 0 is the xor of lanes 3 and 1: a lane out of step
   // or a missed re-inversion breaks that relation, since a plain complement upsets the xor lane
   assign nib = {bit_reg[1], bit_reg[1], bit_reg[0], ^bit_reg} ^ {4{invert_on && slot_reg < 4'h5}};
   assign ref_bit = slot_reg == 4'h4 ? ~par_reg : slot_reg == 4'h9 ? par_reg :
                    nib[2'(slot_reg < 4'h5 ? 4'h3 - slot_reg : 4'h8 - slot_reg)];
   always_ff @(posedge clk or negedge reset_n)
      if (!reset_n)
      begin
         slot_reg <= 4'h0;
         par_reg <= 1'b0;
         bit_reg <= 2'h0;
      end
      else
      begin
         slot_reg <= slot_reg == 4'h9 ? 4'h0 : slot_reg + 4'h1;
         par_reg <= (slot_reg == 4'h4 || slot_reg == 4'h9) ? 1'b0 : par_reg ^ ref_bit;
         bit_reg <= 2'($urandom);
      end
   always_ff @(posedge clk or negedge reset_n)
      for (int i = 0; i < 5; i++)
         line_reg[i] <= !reset_n ? 32'h0 : {line_reg[i][30:0], i < 4 ? nib[i] : ref_bit};
   always_comb
      for (int i = 0; i < 4; i++)
         rx_lane_data[i] = line_reg[i][LANE_DLY[i]] & ~stuck_mask[i];
   assign rx_reference_lane = line_reg[4][REF_DLY];
endmodule : source_lane_model
